// ==== shared/spcw_defines.svh ====
/*
 Register offsets, field positions, reset values and timing counts
 for the shared scaler and configuration word block.
 Assumes a 25 MHz system clock and a 14-bit Avalon-MM byte address.
*/
`ifndef SPCW_DEFINES_SVH
`define SPCW_DEFINES_SVH

// Byte addresses on the register bus
`define SPCW_OPT_ADDR     14'h0000
`define SPCW_TMR_ADDR     14'h0004
`define SPCW_CTL_ADDR     14'h0008
`define SPCW_STAT_ADDR    14'h000C
// Configuration word: printed index, byte address is four times it
`define SPCW_CFG_INDEX    14'h0FFF
`define SPCW_CFG_ADDR     (`SPCW_CFG_INDEX << 2)

// Option register fields
`define SPCW_OPT_W        6
`define SPCW_OPT_RESET    6'h3F
`define SPCW_ASSIGN_BIT   3
`define SPCW_RATIO_MSB    2
`define SPCW_RATIO_LSB    0

// Control register write strobes
`define SPCW_CTL_CLRWD    0
`define SPCW_CTL_SLEEP    1

// Configuration word fields
`define SPCW_CFG_W        12
`define SPCW_CFG_DEFAULT  12'hFFF
`define SPCW_CFG_WATCHDOG_ENABLE_BIT     2
`define SPCW_CFG_CP_LSB   3
`define SPCW_CFG_OSC_MSB  1

// Timing
`define SPCW_CLK_HZ       25000000
`define SPCW_DRT_MS       18
`define SPCW_DRT_CYCLES   ((`SPCW_CLK_HZ / 1000) * `SPCW_DRT_MS)
`define SPCW_INSTR_DIV    4

`endif

// ==== shared/spcw_pkg.sv ====
/*
 Types for the shared scaler and configuration word block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package spcw_pkg;
	typedef enum logic [1:0] {
		SPCW_OSC_LP = 2'h0,
		SPCW_OSC_XT = 2'h1,
		SPCW_OSC_HS = 2'h2,
		SPCW_OSC_RC = 2'h3
	} spcw_osc_t;

	typedef enum logic [2:0] {
		SPCW_ST_HOLD  = 3'h1,
		SPCW_ST_RUN   = 3'h2,
		SPCW_ST_SLEEP = 3'h4
	} spcw_state_t;
endpackage
`default_nettype wire

// ==== rtl/spcw_scaler_core.sv ====
/*
 Shared 8-bit scaler for the timer or the watchdog, timer count,
 watchdog counter, reset timer, sleep control and configuration word,
 behind an Avalon-MM slave with waitrequest.
 Assumes oscillator and watchdog RC pins are asynchronous to i_clk_sys
 and toggle well below a quarter of its rate.
*/
// Implementation choice: the Avalon-MM slave port.
`include "spcw_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module spcw_scaler_core #(
	parameter int unsigned                   P_DRT_CYCLES  = `SPCW_DRT_CYCLES,
	// Fuse contents; value is a neutral default
	parameter logic [`SPCW_CFG_W-1:0]        P_CONFIG_WORD = `SPCW_CFG_DEFAULT,
	parameter bit                            P_SINGLE_CP   = 1'b0
) (
	// Clock and reset
	input  wire logic                        i_clk_sys,
	input  wire logic                        i_rst_b,
	// Avalon-MM slave
	input  wire logic [13:0]                 i_avs_address,
	input  wire logic                        i_avs_read,
	input  wire logic                        i_avs_write,
	input  wire logic [31:0]                 i_avs_writedata,
	input  wire logic [3:0]                  i_avs_byteenable,
	output logic      [31:0]                 o_avs_readdata,
	output logic                             o_avs_waitrequest,
	// Pins
	input  wire logic                        i_osc_input_pin,
	input  wire logic                        i_wdt_rc_osc,
	// Device status
	output logic                             o_chip_reset,
	output logic                             o_wdt_timeout,
	output logic                             o_sleeping,
	output logic      [1:0]                  o_osc_select_field,
	output logic                             o_ext_clock_accept,
	output logic                             o_code_protected,
	output logic                             o_wdt_enabled
);
	// Ratio n selects a mask of low scaler bits that must all be ones
	function automatic logic [7:0] scaler_mask(input logic to_wdt,
		input logic [2:0] n);
		logic [8:0] m;
		m = (9'h001 << ({1'b0, n} + {3'h0, ~to_wdt})) - 9'h001;
		return m[7:0];
	endfunction

	function automatic logic hit_addr(input logic [13:0] a,
		input logic [13:0] b);
		return a == b;
	endfunction

	logic [`SPCW_OPT_W-1:0] option_reg;
	logic [7:0]             scaler_reg;
	logic [7:0]             timer_count_reg;
	logic [7:0]             wdt_count_reg;
	logic                   timeout_flag_reg;
	logic                   ack_reg;
	logic [31:0]            rdata_reg;
	logic [1:0]             instr_div_reg;
	logic [$clog2(`SPCW_DRT_CYCLES+1)-1:0] drt_reg;
	spcw_pkg::spcw_state_t  state_reg;
	logic                   osc_meta_reg, osc_sync_reg, osc_prev_reg;
	logic                   wrc_meta_reg, wrc_sync_reg, wrc_prev_reg;

	logic                   scaler_assign_select;
	logic [2:0]             scaler_ratio_field;
	logic                   watchdog_enable_bit;
	logic [`SPCW_CFG_W-1:0] device_option_word;
	logic                   bus_req, bus_take, wr_take;
	logic                   tmr_wr, opt_wr, ctl_wr;
	logic                   watchdog_clear_instruction, sleep_req;
	logic                   osc_rise, wdt_rise, instr_tick, running;
	logic                   scaler_event, scaler_out;
	logic                   timer_step, wdt_step, wdt_timeout;

	assign scaler_assign_select = option_reg[`SPCW_ASSIGN_BIT];
	assign scaler_ratio_field =
		option_reg[`SPCW_RATIO_MSB:`SPCW_RATIO_LSB];

	// single protection bit variant masks upper bits
	assign device_option_word = P_SINGLE_CP ?
		{8'h00, P_CONFIG_WORD[3:0]} : P_CONFIG_WORD;
	// watchdog enable comes only from the fuse
	assign watchdog_enable_bit = device_option_word[`SPCW_CFG_WATCHDOG_ENABLE_BIT];
	// any zero in the protection field turns protection on
	assign o_code_protected = P_SINGLE_CP ?
		~device_option_word[`SPCW_CFG_CP_LSB] :
		~&device_option_word[`SPCW_CFG_W-1:`SPCW_CFG_CP_LSB];
	// oscillator selection straight from the fuse
	assign o_osc_select_field = device_option_word[`SPCW_CFG_OSC_MSB:0];
	// external clock allowed in all crystal modes
	assign o_ext_clock_accept = (o_osc_select_field !=
		spcw_pkg::SPCW_OSC_RC);
	assign o_wdt_enabled = watchdog_enable_bit;

	// Bus: one wait cycle, answer on the second edge
	assign bus_req           = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = bus_req & ~ack_reg;
	assign bus_take          = bus_req & ~ack_reg;
	// Writes act at the completing edge, when waitrequest is low
	assign wr_take           = bus_req & ack_reg & i_avs_write &
		i_avs_byteenable[0];
	assign opt_wr = wr_take & hit_addr(i_avs_address, `SPCW_OPT_ADDR);
	assign tmr_wr = wr_take & hit_addr(i_avs_address, `SPCW_TMR_ADDR);
	assign ctl_wr = wr_take & hit_addr(i_avs_address, `SPCW_CTL_ADDR);
	assign watchdog_clear_instruction = ctl_wr &
		i_avs_writedata[`SPCW_CTL_CLRWD];
	assign sleep_req = ctl_wr & i_avs_writedata[`SPCW_CTL_SLEEP];
	assign o_avs_readdata = rdata_reg;

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= bus_take;
		end
	end

	// scaler never appears in the read map
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_reg <= 32'h0000_0000;
		end else if (bus_take && i_avs_read) begin
			rdata_reg <= 32'h0000_0000;
			if (hit_addr(i_avs_address, `SPCW_OPT_ADDR)) begin
				rdata_reg[`SPCW_OPT_W-1:0] <= option_reg;
			end else if (hit_addr(i_avs_address, `SPCW_TMR_ADDR)) begin
				rdata_reg[7:0] <= timer_count_reg;
			end else if (hit_addr(i_avs_address, `SPCW_STAT_ADDR)) begin
				rdata_reg[7:0]  <= wdt_count_reg;
				rdata_reg[8]    <= timeout_flag_reg;
				rdata_reg[11:9] <= state_reg;
			end else if (hit_addr(i_avs_address, `SPCW_CFG_ADDR)) begin
				rdata_reg[`SPCW_CFG_W-1:0] <= device_option_word;
			end
		end
	end

	// Pin synchronisers; edges come from the second and third stages only
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			osc_meta_reg <= 1'b0;
			osc_sync_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
			wrc_meta_reg <= 1'b0;
			wrc_sync_reg <= 1'b0;
			wrc_prev_reg <= 1'b0;
		end else begin
			osc_meta_reg <= i_osc_input_pin;
			osc_sync_reg <= osc_meta_reg;
			osc_prev_reg <= osc_sync_reg;
			wrc_meta_reg <= i_wdt_rc_osc;
			wrc_sync_reg <= wrc_meta_reg;
			wrc_prev_reg <= wrc_sync_reg;
		end
	end
	assign osc_rise = osc_sync_reg & ~osc_prev_reg;
	// watchdog ticks from its own RC oscillator
	assign wdt_rise = wrc_sync_reg & ~wrc_prev_reg;

	// Instruction cycle is oscillator divided by four
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			instr_div_reg <= 2'h0;
		end else if (osc_rise) begin
			instr_div_reg <= instr_div_reg + 2'h1;
		end
	end
	assign running    = (state_reg == spcw_pkg::SPCW_ST_RUN);
	// Core stops in sleep, so the timer source stops too
	assign instr_tick = osc_rise & (instr_div_reg ==
		2'(`SPCW_INSTR_DIV - 1)) & running;

	// one scaler, input chosen by the assignment bit
	// zero picks the timer, one the watchdog
	assign scaler_event = scaler_assign_select ? wdt_rise : instr_tick;
	// full period reached when masked low bits are all ones
	assign scaler_out = scaler_event & ((scaler_reg &
		scaler_mask(scaler_assign_select, scaler_ratio_field)) ==
		scaler_mask(scaler_assign_select, scaler_ratio_field));

	// assigned unit steps once per scaler period
	// Without the scaler the timer counts every instruction cycle
	assign timer_step = scaler_assign_select ? instr_tick : scaler_out;
	assign wdt_step   = scaler_assign_select ? scaler_out : wdt_rise;
	assign wdt_timeout = watchdog_enable_bit & wdt_step &
		(wdt_count_reg == 8'hFF) & ~o_chip_reset &
		~watchdog_clear_instruction;
	assign o_wdt_timeout = wdt_timeout;

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			scaler_reg <= 8'h00;
		end else if (wdt_timeout) begin
			// watchdog reset clears it as well
			scaler_reg <= 8'h00;
		end else if (tmr_wr && !scaler_assign_select) begin
			scaler_reg <= 8'h00;
		end else if (watchdog_clear_instruction && scaler_assign_select) begin
			scaler_reg <= 8'h00;
		end else if (scaler_event) begin
			scaler_reg <= scaler_reg + 8'h01;
		end
	end

	// option may be rewritten at any time
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			option_reg <= `SPCW_OPT_RESET;
		end else if (wdt_timeout) begin
			option_reg <= `SPCW_OPT_RESET;
		end else if (opt_wr) begin
			option_reg <= i_avs_writedata[`SPCW_OPT_W-1:0];
		end
	end

	// Timer count keeps its value across a watchdog reset
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			timer_count_reg <= 8'h00;
		end else if (tmr_wr) begin
			timer_count_reg <= i_avs_writedata[7:0];
		end else if (timer_step) begin
			timer_count_reg <= timer_count_reg + 8'h01;
		end
	end

	// clear instruction resets the watchdog counter
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wdt_count_reg <= 8'h00;
		end else if (watchdog_clear_instruction || wdt_timeout) begin
			wdt_count_reg <= 8'h00;
		end else if (watchdog_enable_bit && wdt_step && !o_chip_reset) begin
			wdt_count_reg <= wdt_count_reg + 8'h01;
		end
	end

	// Timeout flag: clear wins over set, as it masks wdt_timeout
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			timeout_flag_reg <= 1'b0;
		end else if (wdt_timeout) begin
			timeout_flag_reg <= 1'b1;
		end else if (watchdog_clear_instruction) begin
			timeout_flag_reg <= 1'b0;
		end
	end

	// reset timer restarts on every device reset
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			drt_reg <= '0;
		end else if (wdt_timeout) begin
			drt_reg <= '0;
		end else if (state_reg == spcw_pkg::SPCW_ST_HOLD) begin
			drt_reg <= drt_reg + 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= spcw_pkg::SPCW_ST_HOLD;
		end else begin
			case (state_reg)
				spcw_pkg::SPCW_ST_HOLD: begin
					if (32'(drt_reg) >= P_DRT_CYCLES - 1) begin
						state_reg <= spcw_pkg::SPCW_ST_RUN;
					end
				end
				spcw_pkg::SPCW_ST_RUN: begin
					if (wdt_timeout) begin
						state_reg <= spcw_pkg::SPCW_ST_HOLD;
					end else if (sleep_req) begin
						state_reg <= spcw_pkg::SPCW_ST_SLEEP;
					end
				end
				spcw_pkg::SPCW_ST_SLEEP: begin
					// only a watchdog timeout wakes it here
					if (wdt_timeout) begin
						state_reg <= spcw_pkg::SPCW_ST_HOLD;
					end
				end
				default: begin
					state_reg <= spcw_pkg::SPCW_ST_HOLD;
				end
			endcase
		end
	end
	assign o_chip_reset = (state_reg == spcw_pkg::SPCW_ST_HOLD);
	assign o_sleeping   = (state_reg == spcw_pkg::SPCW_ST_SLEEP);

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_b);

	a_scaler_reset_zero: assert property (
		wdt_timeout |=> scaler_reg == 8'h00)
		else $error("scaler not zero after watchdog reset");
	a_timer_write_clear: assert property (
		tmr_wr && !scaler_assign_select && !wdt_timeout
		|=> scaler_reg == 8'h00 && timer_count_reg == $past(i_avs_writedata[7:0]))
		else $error("timer write did not clear scaler");
	a_clear_both_units: assert property (
		watchdog_clear_instruction && scaler_assign_select
		|=> scaler_reg == 8'h00 && wdt_count_reg == 8'h00)
		else $error("watchdog clear missed a counter");
	a_timer_step_only: assert property (
		!tmr_wr && !timer_step |=> $stable(timer_count_reg))
		else $error("timer moved without scaler output");
	a_wdt_fuse_off: assert property (
		!watchdog_enable_bit |-> !o_wdt_timeout && wdt_count_reg == 8'h00)
		else $error("disabled watchdog is counting");
	a_sleep_exit_cause: assert property (
		o_sleeping && !wdt_timeout |=> o_sleeping)
		else $error("sleep left without watchdog timeout");
	a_reset_timer_hold: assert property (
		wdt_timeout |=> o_chip_reset [*8])
		else $error("reset timer released too early");
	a_ratio_wdt_direct: assert property (
		scaler_assign_select && scaler_ratio_field == 3'h0 && scaler_event
		|-> scaler_out)
		else $error("watchdog 1:1 ratio not passing events");
	a_timer_ratio_two: assert property (
		!scaler_assign_select && scaler_ratio_field == 3'h0 && scaler_out
		|-> scaler_reg[0])
		else $error("timer 1:2 ratio wrong");
	a_bus_one_wait: assert property (
		bus_req && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("bus answer not after one wait cycle");
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
/*
 Self-checking bench for the shared scaler and configuration word core.
 Assumes the core's one-wait Avalon-MM slave and 2-FF synced pin inputs.
*/
`include "spcw_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int unsigned P_DRT = 20;
	localparam logic [11:0] P_CFG = 12'h006;
	logic        i_clk_sys = 1'b0;
	logic        i_rst_b = 1'b0;
	logic [13:0] i_avs_address = 14'h0000;
	logic        i_avs_read = 1'b0;
	logic        i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h00000000;
	logic [3:0]  i_avs_byteenable = 4'hF;
	logic        i_osc_input_pin = 1'b0;
	logic        i_wdt_rc_osc = 1'b0;
	logic [31:0] o_avs_readdata;
	logic        o_avs_waitrequest;
	logic        o_chip_reset;
	logic        o_wdt_timeout;
	logic        o_sleeping;
	logic [1:0]  o_osc_select_field;
	logic        o_ext_clock_accept;
	logic        o_code_protected;
	logic        o_wdt_enabled;
	int          n_errors = 0;
	int          checks = 0;
	int          n_to = 0;
	logic [31:0] rd;
	int          r, k, n, m_tmr;

	spcw_scaler_core #(.P_DRT_CYCLES(P_DRT), .P_CONFIG_WORD(P_CFG),
		.P_SINGLE_CP(1'b0)) i_dut (
		.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
		.i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
		.i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable),
		.o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.i_osc_input_pin(i_osc_input_pin), .i_wdt_rc_osc(i_wdt_rc_osc),
		.o_chip_reset(o_chip_reset), .o_wdt_timeout(o_wdt_timeout),
		.o_sleeping(o_sleeping), .o_osc_select_field(o_osc_select_field),
		.o_ext_clock_accept(o_ext_clock_accept),
		.o_code_protected(o_code_protected), .o_wdt_enabled(o_wdt_enabled));

	always #20 i_clk_sys = ~i_clk_sys;

	always @(posedge i_clk_sys) begin
		if (o_wdt_timeout === 1'b1)
			n_to <= n_to + 1;
	end

	task automatic tally_and_finish();
		if (n_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// Holds the request until waitrequest is sampled low
	task automatic bus(input logic w, input logic [13:0] a,
		input logic [31:0] d, input logic [3:0] be);
		int c;
		c = 0;
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_byteenable <= be;
		if (w)
			i_avs_write <= 1'b1;
		else
			i_avs_read <= 1'b1;
		do begin
			@(posedge i_clk_sys);
			c++;
		end while (o_avs_waitrequest !== 1'b0 && c < 20);
		if (c >= 20) begin
			n_errors++;
			tally_and_finish();
		end
		rd = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		@(posedge i_clk_sys);
	endtask

	task automatic wr(input logic [13:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask

	task automatic rdm(input logic [13:0] a, input logic [31:0] mask,
		input logic [31:0] e);
		bus(1'b0, a, 32'h00000000, 4'hF);
		check(rd & mask, e);
	endtask

	// Slow pin edges, one every four bus clocks, a rising edge every eight
	task automatic pulses(input logic rc, input int e);
		repeat (e) begin
			if (rc)
				i_wdt_rc_osc <= 1'b1;
			else
				i_osc_input_pin <= 1'b1;
			repeat (4) @(posedge i_clk_sys);
			i_wdt_rc_osc <= 1'b0;
			i_osc_input_pin <= 1'b0;
			repeat (4) @(posedge i_clk_sys);
		end
		repeat (6) @(posedge i_clk_sys);
	endtask

	task automatic wait_run(output int c);
		c = 0;
		while (o_chip_reset !== 1'b0 && c < 200) begin
			@(posedge i_clk_sys);
			c++;
		end
		if (c >= 200) begin
			n_errors++;
			tally_and_finish();
		end
	endtask

	initial begin
		r = $urandom(23779);
		repeat (3) @(posedge i_clk_sys);
		check({31'h0, o_chip_reset}, 32'h1);
		i_rst_b <= 1'b1;
		wait_run(n);
		check({31'h0, n >= P_DRT - 2 && n <= P_DRT + 3}, 32'h1);
		rdm(`SPCW_STAT_ADDR, 32'h00000FFF, 32'h00000400);
		rdm(`SPCW_OPT_ADDR, 32'h0000003F, 32'h0000003F);
		rdm(`SPCW_CFG_ADDR, 32'h00000FFF, {20'h0, P_CFG});
		wr(`SPCW_CFG_ADDR, 32'h00000FFF);
		rdm(`SPCW_CFG_ADDR, 32'h00000FFF, {20'h0, P_CFG});
		rdm(14'h0010, 32'hFFFFFFFF, 32'h00000000);
		check({30'h0, o_osc_select_field}, 32'h2);
		check({31'h0, o_ext_clock_accept}, 32'h1);
		check({31'h0, o_code_protected}, 32'h1);
		check({31'h0, o_wdt_enabled}, 32'h1);
		bus(1'b1, `SPCW_OPT_ADDR, 32'h00000000, 4'h0);
		rdm(`SPCW_OPT_ADDR, 32'h0000003F, 32'h0000003F);
		wr(`SPCW_CTL_ADDR, 32'h00000001);
		// Edge counts of M*k+2 make the result immune to cycle phase
		for (int i = 0; i < 8; i++) begin
			wr(`SPCW_OPT_ADDR, i);
			r = $urandom % 256;
			wr(`SPCW_TMR_ADDR, r);
			k = (i < 3) ? 3 : 1;
			pulses(1'b0, (4 << (i + 1)) * k + 2);
			m_tmr = (r + k) % 256;
			rdm(`SPCW_TMR_ADDR, 32'h000000FF, m_tmr);
		end
		// timer write drops partial scaler count
		wr(`SPCW_OPT_ADDR, 32'h00000002);
		pulses(1'b0, 28);
		wr(`SPCW_TMR_ADDR, 32'h00000040);
		pulses(1'b0, 18);
		rdm(`SPCW_TMR_ADDR, 32'h000000FF, 32'h00000040);
		// timer to watchdog, ratio 000 needs the temporary value
		wr(`SPCW_CTL_ADDR, 32'h00000001);
		wr(`SPCW_TMR_ADDR, 32'h00000000);
		wr(`SPCW_OPT_ADDR, 32'h0000000F);
		wr(`SPCW_CTL_ADDR, 32'h00000001);
		wr(`SPCW_OPT_ADDR, 32'h00000008);
		pulses(1'b1, 100);
		rdm(`SPCW_STAT_ADDR, 32'h000000FF, 32'h00000064);
		pulses(1'b0, 20);
		rdm(`SPCW_TMR_ADDR, 32'h000000FF, 32'h00000005);
		wr(`SPCW_CTL_ADDR, 32'h00000001);
		wr(`SPCW_OPT_ADDR, 32'h0000000A);
		pulses(1'b1, 42);
		rdm(`SPCW_STAT_ADDR, 32'h000001FF, 32'h0000000A);
		pulses(1'b1, 3);
		wr(`SPCW_CTL_ADDR, 32'h00000001);
		pulses(1'b1, 3);
		rdm(`SPCW_STAT_ADDR, 32'h000001FF, 32'h00000000);
		// Sleep left only by a watchdog overflow
		wr(`SPCW_OPT_ADDR, 32'h00000008);
		wr(`SPCW_CTL_ADDR, 32'h00000001);
		wr(`SPCW_CTL_ADDR, 32'h00000002);
		wr(`SPCW_TMR_ADDR, 32'h0000005A);
		check({31'h0, o_sleeping}, 32'h1);
		rdm(`SPCW_STAT_ADDR, 32'h00000E00, 32'h00000800);
		pulses(1'b1, 255);
		check(n_to, 32'h0);
		check({31'h0, o_sleeping}, 32'h1);
		pulses(1'b1, 1);
		check(n_to, 32'h1);
		check({31'h0, o_sleeping}, 32'h0);
		check({31'h0, o_chip_reset}, 32'h1);
		wait_run(n);
		rdm(`SPCW_OPT_ADDR, 32'h0000003F, 32'h0000003F);
		rdm(`SPCW_TMR_ADDR, 32'h000000FF, 32'h0000005A);
		// Second external reset in mid-run
		wr(`SPCW_OPT_ADDR, 32'h00000001);
		i_rst_b <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		check({31'h0, o_chip_reset}, 32'h1);
		i_rst_b <= 1'b1;
		wait_run(n);
		rdm(`SPCW_OPT_ADDR, 32'h0000003F, 32'h0000003F);
		tally_and_finish();
	end
endmodule
`default_nettype wire
